// ===== hlt_pkg.sv
// Purpose: shared constants and types for the hardware limit timer
// Assumes: 32-bit axi4-lite register bus, one clock
// Notes: offsets are byte addresses
// Notes on behaviour
// - postscale code N gives one postscaler output per N+1 matches
// - timer advances only while timer_on is set
// - prescale 00 is /1, 01 is /4, 1x is /16
// - reset source codes 000..101 select ccp, cmp1, cmp2, fault, out a, out b
// - reserved source codes 110, 111 feed constant zero
// - falling enable clears count on first clock after falling source edge
// - rising enable clears count on first clock after rising source edge
// - unimplemented control bits read zero, writes ignored
// - every reset forces all control fields to zero
// - period register is software accessible, compared against count
// - count equal period asserts limit, clears count next edge, advances postscaler
// - postscaler overflow sets interrupt flag, forwarded only while enabled
// - writes to count or ctrl0 clear pre- and postscaler; ctrl0 keeps count
// - external edge clears give no limit event nor postscaler advance
package hlt_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_RESET_CTRL = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam logic [3:0] ADDR_PERIOD = 4'hc;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h14;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h18;
  localparam int ADDR_BITS = 5;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTRL0_PRESCALE_LSB = 0;
  localparam int CTRL0_ON_BIT = 2;
  localparam int CTRL0_POSTSCALE_LSB = 3;
  localparam int RCTRL_RISE_BIT = 0;
  localparam int RCTRL_FALL_BIT = 1;
  localparam int RCTRL_SOURCE_LSB = 2;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] PRESCALE_DIV1 = 2'b00;
  localparam logic [1:0] PRESCALE_DIV4 = 2'b01;
  localparam logic [3:0] PRESCALE_MASK4 = 4'h3;
  localparam logic [3:0] PRESCALE_MASK16 = 4'hf;

  typedef enum logic [2:0] {
    SRC_CAPTURE = 3'b000,
    SRC_CMP_ONE = 3'b001,
    SRC_CMP_TWO = 3'b010,
    SRC_FAULT = 3'b011,
    SRC_OUT_A = 3'b100,
    SRC_OUT_B = 3'b101
  } hlt_source_t;

  typedef struct packed {
    logic [3:0] postscale_select;
    logic timer_on;
    logic [1:0] prescale_select;
  } hlt_ctrl0_t;

  typedef struct packed {
    logic [2:0] reset_source_select;
    logic falling_reset_enable;
    logic rising_reset_enable;
  } hlt_rctrl_t;

  typedef struct packed {
    logic capture_compare_unit;
    logic comparator_one_out;
    logic comparator_two_out;
    logic waveform_gen_fault;
    logic waveform_gen_out_a;
    logic waveform_gen_out_b;
  } hlt_sources_t;

endpackage

// ===== hlt_src_edge.sv
// Purpose: reset source select and edge detect
// Assumes: sources synchronous to aclk
// Notes: one cycle edge pulse
`timescale 1ns/100ps
module hlt_src_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire hlt_pkg::hlt_sources_t sources,
  input wire hlt_pkg::hlt_rctrl_t rctrl,
  output logic edge_clear
);
  logic selected;
  logic last;

  always_comb begin
    case (rctrl.reset_source_select)
      hlt_pkg::SRC_CAPTURE: selected = sources.capture_compare_unit;
      hlt_pkg::SRC_CMP_ONE: selected = sources.comparator_one_out;
      hlt_pkg::SRC_CMP_TWO: selected = sources.comparator_two_out;
      hlt_pkg::SRC_FAULT: selected = sources.waveform_gen_fault;
      hlt_pkg::SRC_OUT_A: selected = sources.waveform_gen_out_a;
      hlt_pkg::SRC_OUT_B: selected = sources.waveform_gen_out_b;
      default: selected = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last <= 1'b0;
    end else begin
      last <= selected;
    end
  end

  assign edge_clear = (rctrl.rising_reset_enable && selected && !last) ||
                      (rctrl.falling_reset_enable && !selected && last);
endmodule

// ===== hlt_postscale.sv
// Purpose: match postscaler
// Assumes: match is a one cycle pulse
// Notes: overflow is a one cycle pulse
`timescale 1ns/100ps
module hlt_postscale #(
  parameter int WIDTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic match,
  input wire logic [WIDTH-1:0] select,
  output logic overflow
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count <= '0;
    end else if (match) begin
      count <= (count == select) ? '0 : count + 1'b1;
    end
  end

  assign overflow = match && !clear && (count == select);
endmodule

// ===== hlt_timer.sv
// Purpose: hardware limit timer with axi4-lite registers
// Assumes: 20 MHz aclk is the timer clock, inputs synchronous
// Notes: limit_out pulses one cycle per match
`timescale 1ns/100ps
module hlt_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire hlt_pkg::hlt_sources_t sources,
  output logic limit_out,
  output logic irq
);
  // ****************************************
  // state
  // ****************************************
  hlt_pkg::hlt_ctrl0_t ctrl0;
  hlt_pkg::hlt_rctrl_t rctrl;
  logic [7:0] limit_count;
  logic [7:0] limit_period;
  logic [3:0] prescale;
  logic limit_irq_flag;
  logic limit_irq_enable;
  logic aw_held;
  logic w_held;
  logic [4:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic wr_ctrl0;
  logic wr_count;
  logic edge_clear;
  logic tick;
  logic match;
  logic overflow;
  logic psc_clear;
  logic [3:0] psc_mask;

  // ****************************************
  // write channel
  // ****************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 5'h0_0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= hlt_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr <= hlt_pkg::ADDR_IRQ_CLEAR && aw_addr[1:0] == 2'b00)
                     ? hlt_pkg::RESP_OKAY : hlt_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign wr_ctrl0 = wr_go && w_strb[0] && aw_addr == 5'(hlt_pkg::ADDR_CTRL0);
  assign wr_count = wr_go && w_strb[0] && aw_addr == 5'(hlt_pkg::ADDR_COUNT);

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0 <= '0;
    end else if (wr_ctrl0) begin
      ctrl0 <= w_data[6:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rctrl <= '0;
    end else if (wr_go && w_strb[0] && aw_addr == 5'(hlt_pkg::ADDR_RESET_CTRL)) begin
      rctrl <= w_data[4:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_period <= hlt_pkg::PERIOD_RESET;
    end else if (wr_go && w_strb[0] && aw_addr == 5'(hlt_pkg::ADDR_PERIOD)) begin
      limit_period <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_irq_enable <= 1'b0;
    end else if (wr_go && w_strb[0] && aw_addr == hlt_pkg::ADDR_IRQ_ENABLE) begin
      limit_irq_enable <= w_data[0];
    end
  end

  // ****************************************
  // prescaler and count
  // ****************************************
  assign psc_clear = wr_ctrl0 || wr_count;

  always_comb begin
    case (ctrl0.prescale_select)
      hlt_pkg::PRESCALE_DIV1: psc_mask = 4'h0;
      hlt_pkg::PRESCALE_DIV4: psc_mask = hlt_pkg::PRESCALE_MASK4;
      default: psc_mask = hlt_pkg::PRESCALE_MASK16;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || psc_clear) begin
      prescale <= 4'h0;
    end else if (ctrl0.timer_on) begin
      prescale <= ((prescale & psc_mask) == psc_mask) ? 4'h0 : prescale + 4'h1;
    end
  end

  assign tick = ctrl0.timer_on && ((prescale & psc_mask) == psc_mask);
  assign match = tick && !edge_clear && (limit_count == limit_period);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_count <= hlt_pkg::COUNT_RESET;
    end else if (wr_count) begin
      limit_count <= w_data[7:0];
    end else if (edge_clear) begin
      limit_count <= hlt_pkg::COUNT_RESET;
    end else if (match) begin
      limit_count <= hlt_pkg::COUNT_RESET;
    end else if (tick) begin
      limit_count <= limit_count + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_out <= 1'b0;
    end else begin
      limit_out <= match;
    end
  end

  hlt_src_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .sources(sources),
    .rctrl(rctrl),
    .edge_clear(edge_clear)
  );

  hlt_postscale #(.WIDTH(4)) u_post (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(psc_clear),
    .match(match),
    .select(ctrl0.postscale_select),
    .overflow(overflow)
  );

  // ****************************************
  // interrupt
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_irq_flag <= 1'b0;
    end else if (overflow) begin
      limit_irq_flag <= 1'b1;
    end else if (wr_go && w_strb[0] && aw_addr == hlt_pkg::ADDR_IRQ_CLEAR && w_data[0]) begin
      limit_irq_flag <= 1'b0;
    end
  end

  assign irq = limit_irq_flag && limit_irq_enable;

  // ****************************************
  // read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= hlt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= hlt_pkg::RESP_OKAY;
      case (s_axi_araddr)
        5'(hlt_pkg::ADDR_CTRL0): s_axi_rdata <= {25'h0, ctrl0};
        5'(hlt_pkg::ADDR_RESET_CTRL): s_axi_rdata <= {27'h0, rctrl};
        5'(hlt_pkg::ADDR_COUNT): s_axi_rdata <= {24'h0, limit_count};
        5'(hlt_pkg::ADDR_PERIOD): s_axi_rdata <= {24'h0, limit_period};
        hlt_pkg::ADDR_IRQ_STATUS: s_axi_rdata <= {31'h0, limit_irq_flag};
        hlt_pkg::ADDR_IRQ_ENABLE: s_axi_rdata <= {31'h0, limit_irq_enable};
        hlt_pkg::ADDR_IRQ_CLEAR: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= hlt_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ===== hlt_src_model.sv
// Purpose: stand-in for the peripheral reset sources
// Assumes: sel and lvl change just after aclk edges
// Notes: codes above five drive every source with lvl
`timescale 1ns/100ps
module hlt_src_model (
  input wire logic [2:0] sel,
  input wire logic lvl,
  output hlt_pkg::hlt_sources_t sources
);
  // ****
  // source drive
  // ****
  always_comb begin
    if (sel > 3'h5) begin
      sources = hlt_pkg::hlt_sources_t'({6{lvl}});
    end else begin
      sources = hlt_pkg::hlt_sources_t'({5'h00, lvl} << (3'h5 - sel));
    end
  end
endmodule

// ===== hlt_timer_assertions.sv
// Purpose: port checks for hlt_timer
// Assumes: one clock, synchronous low reset
// Notes: bound to every hlt_timer
`timescale 1ns/100ps
module hlt_timer_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic limit_out,
  input wire logic irq
);
  // ****
  // checks
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  r_hold_a: assert property (rd_waiting |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read late");
  resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad bresp");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper bits set");
  rst_quiet_a: assert property ($rose(aresetn) |-> !irq && !limit_out)
    else $error("output after reset");
endmodule
bind hlt_timer hlt_timer_assertions u_chk (.aclk, .aresetn, .s_axi_awready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .limit_out, .irq);

// ===== hlt_timer_tb_top.sv
// Purpose: self-checking bench for hlt_timer
// Assumes: 20 MHz aclk, 6-cycle reset
// Notes: sources come from hlt_src_model
`timescale 1ns/100ps
module hlt_timer_tb_top;
  // ****
  // bench
  // ****
  logic aclk = 1'b0, aresetn = 1'b0, lvl = 1'b0;
  logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, sel = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, limit_out, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  hlt_pkg::hlt_sources_t sources;
  int n_errors = 0, samples_checked = 0;
  logic [31:0] d;
  logic [1:0] r;
  always #25 aclk = ~aclk;
  hlt_timer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sources, .limit_out, .irq);
  hlt_src_model model (.sel, .lvl, .sources);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    bit da, dw;
    da = 0;
    dw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      da = da | s_axi_awready;
      dw = dw | s_axi_wready;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
    end while (!(da && dw));
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic gap(output int c);
    c = 0;
    do @(negedge aclk); while (limit_out !== 1'b1);
    do begin
      @(negedge aclk);
      c++;
    end while (limit_out !== 1'b1 && c < 2000);
  endtask
  task automatic t_regs();
    rd(5'h00);
    chk(d, 32'h0);
    rd(5'h0c);
    chk(d, 32'hff);
    wr(5'h00, 8'h80);
    rd(5'h00);
    chk(d, 32'h0);
    wr(5'h04, 8'hff);
    rd(5'h04);
    chk(d, 32'h1f);
    wr(5'h08, 8'h3c);
    rd(5'h08);
    chk(d, 32'h3c);
    wr(5'h00, 8'hfb);
    rd(5'h08);
    chk(d, 32'h3c);
    rd(5'h00);
    chk(d, 32'h7b);
    wr(5'h1c, 8'h01);
    chk(r, 2'h2);
    rd(5'h1c);
    chk({d[29:0], r}, 32'h2);
    $display("registers done");
  endtask
  task automatic t_presc();
    int c;
    wr(5'h0c, 8'h05);
    wr(5'h08, 8'h00);
    for (int ps = 0; ps < 4; ps++) begin
      wr(5'h00, {5'h01, ps[1:0]});
      gap(c);
      chk(c, 6 * (ps == 0 ? 1 : ps == 1 ? 4 : 16));
    end
    $display("prescale done");
  endtask
  task automatic t_post();
    int p;
    int ns[3] = '{0, 2, 15};
    wr(5'h0c, 8'h20);
    wr(5'h14, 8'h01);
    for (int i = 0; i < 3; i++) begin
      wr(5'h00, {1'b0, ns[i][3:0], 3'h0});
      wr(5'h18, 8'h01);
      chk(irq, 1'b0);
      wr(5'h00, {1'b0, ns[i][3:0], 3'h4});
      p = 0;
      do begin
        @(negedge aclk);
        p += limit_out;
      end while (irq !== 1'b1 && p < 40);
      chk(p, ns[i] + 1);
    end
    wr(5'h00, 8'h00);
    wr(5'h14, 8'h00);
    chk(irq, 1'b0);
    rd(5'h10);
    chk(d, 32'h1);
    wr(5'h18, 8'h01);
    rd(5'h10);
    chk(d, 32'h0);
    $display("postscale done");
  endtask
  task automatic t_edge();
    logic up;
    int p;
    wr(5'h0c, 8'hff);
    wr(5'h00, 8'h04);
    for (int s = 0; s < 8; s++) begin
      for (int m = 0; m < 2; m++) begin
        up = !lvl;
        sel <= s[2:0];
        wr(5'h04, {3'h0, s[2:0], !up ^ m[0], up ^ m[0]});
        wr(5'h08, 8'h00);
        repeat (40) @(posedge aclk);
        lvl <= up;
        repeat (2) @(posedge aclk);
        rd(5'h08);
        chk(d < 32'h14, s < 6 && m == 0);
      end
    end
    sel <= 3'h0;
    wr(5'h0c, 8'h20);
    wr(5'h04, 8'h03);
    wr(5'h08, 8'h00);
    p = 0;
    for (int i = 0; i < 200; i++) begin
      @(posedge aclk);
      p += limit_out;
      if (i % 20 == 19) lvl <= !lvl;
    end
    chk(p, 0);
    $display("edge reset done");
  endtask
  task automatic t_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(5'h00);
    chk(d, 32'h0);
    rd(5'h04);
    chk(d, 32'h0);
    rd(5'h0c);
    chk(d, 32'hff);
    $display("mid-run reset done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_presc();
    t_post();
    t_edge();
    t_reset();
    wrap_up();
  end
endmodule
